// >>> conveyor_gating_defs.vh
// Constants of the conveyor gating sequencer: times, strap codes, register map.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef CONVEYOR_GATING_DEFS_VH
`define CONVEYOR_GATING_DEFS_VH

// ==================================================================
// Time base
`define CLK_PERIOD_NS    8
`define MS_NS            1000000
`define TICK_CNT_W       17

// ==================================================================
// Times in milliseconds
`define START_WIN_MS     10'h1f4
`define ARM_MS           12'hfa0
`define FILT_LONG_MS     12'h7d0
`define FILT_SHORT_MS    12'h3e8
`define END_MS           12'h064
`define TO_STD_MS        29'h000927c0
`define TO_EXT_MS        29'h15752a00

// ==================================================================
// Mode strap codes
`define STRAP_MODE1      2'h1
`define STRAP_MODE5      2'h2
`define STRAP_MODE6      2'h3

// ==================================================================
// Seven-segment patterns {g,f,e,d,c,b,a}
`define SEG_ONE          7'h06
`define SEG_FIVE         7'h6d
`define SEG_SIX          7'h7d
`define SEG_DASH         7'h40

// ==================================================================
// Register map, byte addresses
`define ADDR_W           8
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_IRQ_STAT     8'h08
`define REG_IRQ_MASK     8'h0c
`define CTRL_BLANK_BIT   0
`define CTRL_RESTART_BIT 1
`define IRQ_W            4
`define IRQ_START_BIT    0
`define IRQ_END_BIT      1
`define IRQ_TRIP_BIT     2
`define IRQ_TIMEOUT_BIT  3
`define IRQ_MASK_RST     4'h0
`define BLANK_TOL_BEAMS  2'h1

`endif

// >>> ms_ticker.v
// Divider giving a one-cycle pulse once per millisecond.
// Assumes a single free-running clock; counts CYCLES clocks per pulse.
`timescale 1ns/1ps
`include "conveyor_gating_defs.vh"

module ms_ticker #(
    parameter CYCLES = 125000,
    parameter W      = `TICK_CNT_W
) (
    input  wire         mclk_i,
    input  wire         arst_n_i,
    output reg          tick_o
);

    reg  [W-1:0] cnt_q;

    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_q  <= {W{1'b0}};
            tick_o <= 1'b0;
        end
        else if (cnt_q == CYCLES[W-1:0] - {{(W-1){1'b0}}, 1'b1})
        begin
            cnt_q  <= {W{1'b0}};
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end

endmodule

// >>> conveyor_gating_sequencer.v
// Gating sequencer of a light curtain receiver with an APB register slave.
// Assumes all pins synchronous to mclk_i and an APB master on the bus side.
//
// Function
// - Mode comes only from strap pins
// - Display selected mode number steadily
// - Ending gating takes 100 ms, less by a qualified stop
// - Bridge field clearing up to mode filter
// - Modes 1/6 start on antivalent change
// - Field must interrupt within 4 s
// - Qualified stop needs no field interruption
// - New antivalent change stops, later restarts
// - Mode 5 gates on request alone
// - Timeout 10 min, 100 h with hold
// - Scan filter, interlock always; qualified stop 1/6
// - Fixed blanking selectable, tolerance one beam
// - Mode 6 top beams trip outputs
// - Request removal ends gating within 100 ms
// - Request 4 s without field trips outputs
`timescale 1ns/1ps
`include "conveyor_gating_defs.vh"

module conveyor_gating_sequencer #(
    parameter TICK_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
    input  wire                 mclk_i,
    input  wire                 arst_n_i,
    input  wire                 psel_i,
    input  wire                 penable_i,
    input  wire                 pwrite_i,
    input  wire [`ADDR_W-1:0]   paddr_i,
    input  wire [31:0]          pwdata_i,
    output reg  [31:0]          prdata_o,
    output reg                  pready_o,
    output reg                  pslverr_o,
    input  wire [1:0]           mode_strap_i,
    input  wire                 switch_req_i,
    input  wire                 timeout_hold_i,
    input  wire                 field_interrupted_i,
    input  wire                 top_beams_interrupted_i,
    output reg                  safety_switch_outputs_o,
    output reg                  gating_on_indication_o,
    output reg                  restart_interlock_o,
    output reg                  multiscan_filter_o,
    output reg                  qualified_stop_en_o,
    output reg                  blanking_en_o,
    output reg  [1:0]           blank_tol_o,
    output reg  [6:0]           seg_o,
    output reg                  irq_o
);

    // ==================================================================
    // States
    localparam S_IDLE  = 6'h01;
    localparam S_ARMED = 6'h02;
    localparam S_GATE  = 6'h04;
    localparam S_CLEAR = 6'h08;
    localparam S_END   = 6'h10;
    localparam S_TRIP  = 6'h20;

    function [6:0] seg_digit;
        input [1:0] code;
        begin
            case (code)
                `STRAP_MODE1: seg_digit = `SEG_ONE;
                `STRAP_MODE5: seg_digit = `SEG_FIVE;
                `STRAP_MODE6: seg_digit = `SEG_SIX;
                default:      seg_digit = `SEG_DASH;
            endcase
        end
    endfunction

    // ==================================================================
    // Declarations
    wire                tick;
    reg  [1:0]          mode_q;
    reg                 strap_done_q;
    reg  [5:0]          state_q;
    reg  [5:0]          state_d;
    reg  [11:0]         ph_q;
    reg  [28:0]         to_q;
    reg                 ext_q;
    reg                 cs_prev_q;
    reg                 th_prev_q;
    reg  [9:0]          age_q [0:3];
    reg  [3:0]          vld_q;
    reg  [3:0]          edge_ev;
    reg  [3:0]          consume;
    reg                 blank_en_q;
    reg                 restart_q;
    reg  [`IRQ_W-1:0]   irq_stat_q;
    reg  [`IRQ_W-1:0]   irq_mask_q;
    reg  [`IRQ_W-1:0]   irq_ev;
    reg                 start_clr;
    reg  [31:0]         rdata;
    reg                 hit;
    wire                strap_ok;
    wire                qs_mode;
    wire                anti_on;
    wire                anti_off;
    wire                start_req;
    wire                active;
    wire                top_trip;
    wire [11:0]         filt_ms;
    wire [28:0]         to_lim;
    wire                apb_setup;
    wire                apb_wr;
    integer             i;

    ms_ticker #(
        .CYCLES (TICK_CYCLES),
        .W      (`TICK_CNT_W)
    ) u_ticker (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .tick_o   (tick)
    );

    // ==================================================================
    // Mode strap, caught once at the first edge after reset release
    // Later changes of the pins are ignored so a loose cable cannot switch modes
    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            mode_q       <= 2'h0;
            strap_done_q <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            mode_q       <= mode_strap_i;
            strap_done_q <= 1'b1;
        end
    end

    assign strap_ok = strap_done_q && (mode_q != 2'h0);
    assign qs_mode  = (mode_q == `STRAP_MODE1) || (mode_q == `STRAP_MODE6);
    assign filt_ms  = (mode_q == `STRAP_MODE5) ? `FILT_SHORT_MS : `FILT_LONG_MS;
    assign to_lim   = ext_q ? `TO_EXT_MS : `TO_STD_MS;
    assign active   = (state_q == S_ARMED) || (state_q == S_GATE) ||
                      (state_q == S_CLEAR) || (state_q == S_END);
    assign top_trip = (mode_q == `STRAP_MODE6) && top_beams_interrupted_i;

    // ==================================================================
    // Edge trackers: 0 request rise, 1 hold fall, 2 request fall, 3 hold rise
    // Each edge stays usable for the pairing window, then is forgotten
    always @*
    begin
        edge_ev[0] = switch_req_i && !cs_prev_q;
        edge_ev[1] = !timeout_hold_i && th_prev_q;
        edge_ev[2] = !switch_req_i && cs_prev_q;
        edge_ev[3] = timeout_hold_i && !th_prev_q;
    end

    assign anti_on   = vld_q[0] && vld_q[1];
    assign anti_off  = qs_mode && vld_q[2] && vld_q[3];
    assign start_req = qs_mode ? anti_on : edge_ev[0];

    always @*
    begin
        consume = 4'h0;
        if (anti_on)
        begin
            consume[0] = 1'b1;
            consume[1] = 1'b1;
        end
        if (anti_off)
        begin
            consume[2] = 1'b1;
            consume[3] = 1'b1;
        end
    end

    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            // Hold idles high while the request idles low, so no false edge follows reset
            cs_prev_q <= 1'b0;
            th_prev_q <= 1'b1;
            vld_q     <= 4'h0;
            for (i = 0; i < 4; i = i + 1)
                age_q[i] <= 10'h000;
        end
        else
        begin
            cs_prev_q <= switch_req_i;
            th_prev_q <= timeout_hold_i;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (edge_ev[i])
                begin
                    age_q[i] <= 10'h000;
                    vld_q[i] <= 1'b1;
                end
                else if (consume[i])
                    vld_q[i] <= 1'b0;
                else if (tick && vld_q[i])
                begin
                    if (age_q[i] >= `START_WIN_MS - 10'h001)
                        vld_q[i] <= 1'b0;
                    else
                        age_q[i] <= age_q[i] + 10'h001;
                end
            end
        end
    end

    // ==================================================================
    // Sequence state machine
    always @*
    begin
        state_d   = state_q;
        irq_ev    = {`IRQ_W{1'b0}};
        start_clr = 1'b0;
        case (state_q)
            S_IDLE:
            begin
                if (strap_ok && start_req)
                begin
                    state_d   = S_ARMED;
                    start_clr = 1'b1;
                    irq_ev[`IRQ_START_BIT] = 1'b1;
                end
            end
            S_ARMED:
            begin
                if (anti_off)
                    state_d = S_IDLE;
                else if (field_interrupted_i)
                    state_d = S_GATE;
                else if (!switch_req_i)
                    state_d = S_END;
                else if (ph_q >= `ARM_MS)
                    state_d = S_TRIP;
            end
            S_GATE:
            begin
                if (anti_off)
                    state_d = S_IDLE;
                else if (!switch_req_i)
                    state_d = S_END;
                else if (!field_interrupted_i)
                    state_d = S_CLEAR;
            end
            S_CLEAR:
            begin
                if (anti_off)
                    state_d = S_IDLE;
                else if (!switch_req_i)
                    state_d = S_END;
                else if (field_interrupted_i)
                    state_d = S_GATE;
                else if (ph_q >= filt_ms)
                    state_d = S_IDLE;
            end
            S_END:
            begin
                // Ends at the minimum time, which is also the maximum, unless a qualified stop (anti_off) ends it sooner
                if (anti_off || ph_q >= `END_MS)
                    state_d = S_IDLE;
            end
            S_TRIP:
            begin
                if (restart_q)
                    state_d = S_IDLE;
            end
            default:
                state_d = S_TRIP;
        endcase
        if (active && (top_trip || to_q >= to_lim))
            state_d = S_TRIP;
        if (active && to_q >= to_lim)
            irq_ev[`IRQ_TIMEOUT_BIT] = 1'b1;
        if (active && state_d == S_IDLE)
            irq_ev[`IRQ_END_BIT] = 1'b1;
        if (state_q != S_TRIP && state_d == S_TRIP)
            irq_ev[`IRQ_TRIP_BIT] = 1'b1;
    end

    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_q <= S_IDLE;
            ph_q    <= 12'h000;
            to_q    <= 29'h00000000;
            ext_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (state_d != state_q)
                ph_q <= 12'h000;
            else if (tick && ph_q != 12'hfff)
                ph_q <= ph_q + 12'h001;
            if (start_clr)
            begin
                to_q  <= 29'h00000000;
                ext_q <= 1'b0;
            end
            else if (active)
            begin
                if (tick)
                    to_q <= to_q + 29'h00000001;
                if (edge_ev[3] && state_q != S_ARMED)
                    ext_q <= 1'b1;
            end
        end
    end

    // ==================================================================
    // Pin outputs, all registered
    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            safety_switch_outputs_o <= 1'b0;
            gating_on_indication_o  <= 1'b0;
            restart_interlock_o     <= 1'b0;
            multiscan_filter_o      <= 1'b0;
            qualified_stop_en_o     <= 1'b0;
            blanking_en_o           <= 1'b0;
            blank_tol_o             <= 2'h0;
            seg_o                   <= 7'h00;
            irq_o                   <= 1'b0;
        end
        else
        begin
            // Outputs other than seg_o, blank_tol_o and blanking_en_o stay off with a bad strap: no mode means no safe behaviour
            safety_switch_outputs_o <= strap_ok && state_q != S_TRIP && !top_trip &&
                                       (!field_interrupted_i || active);
            gating_on_indication_o  <= active;
            restart_interlock_o     <= strap_ok;
            multiscan_filter_o      <= strap_ok;
            qualified_stop_en_o     <= strap_ok && qs_mode;
            blanking_en_o           <= blank_en_q;
            blank_tol_o             <= `BLANK_TOL_BEAMS;
            seg_o                   <= strap_done_q ? seg_digit(mode_q) : `SEG_DASH;
            irq_o                   <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ==================================================================
    // APB slave: data is latched in the setup cycle, so no wait states
    assign apb_setup = psel_i && !penable_i;
    assign apb_wr    = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;

    always @*
    begin
        rdata = 32'h00000000;
        hit   = 1'b1;
        case (paddr_i)
            `REG_CTRL:     rdata[`CTRL_BLANK_BIT] = blank_en_q;
            `REG_STATUS:   rdata[11:0] = {ext_q, !strap_ok, mode_q, state_q, 1'b0,
                                          safety_switch_outputs_o};
            `REG_IRQ_STAT: rdata[`IRQ_W-1:0] = irq_stat_q;
            `REG_IRQ_MASK: rdata[`IRQ_W-1:0] = irq_mask_q;
            default:       hit = 1'b0;
        endcase
    end

    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            prdata_o   <= 32'h00000000;
            pready_o   <= 1'b0;
            pslverr_o  <= 1'b0;
            blank_en_q <= 1'b0;
            restart_q  <= 1'b0;
            irq_stat_q <= {`IRQ_W{1'b0}};
            irq_mask_q <= `IRQ_MASK_RST;
        end
        else
        begin
            pready_o  <= apb_setup;
            pslverr_o <= apb_setup && !hit;
            prdata_o  <= (apb_setup && !pwrite_i) ? rdata : 32'h00000000;
            restart_q <= apb_wr && paddr_i == `REG_CTRL && pwdata_i[`CTRL_RESTART_BIT];
            if (apb_wr && paddr_i == `REG_CTRL)
                blank_en_q <= pwdata_i[`CTRL_BLANK_BIT];
            if (apb_wr && paddr_i == `REG_IRQ_MASK)
                irq_mask_q <= pwdata_i[`IRQ_W-1:0];
            // A new event wins over a clear in the same cycle
            if (apb_wr && paddr_i == `REG_IRQ_STAT)
                irq_stat_q <= (irq_stat_q & ~pwdata_i[`IRQ_W-1:0]) | irq_ev;
            else
                irq_stat_q <= irq_stat_q | irq_ev;
        end
    end

endmodule

// >>> conveyor_gating_sequencer_assertions.sv
// Port checker of the conveyor gating sequencer, bound into every instance.
// Assumes a single clock domain and TICK_CYCLES handed on from the design.
`timescale 1ns/1ps
`include "conveyor_gating_defs.vh"
module conveyor_gating_sequencer_assertions #(
    parameter TICK_CYCLES = 4
) (
    input wire               mclk_i,
    input wire               arst_n_i,
    input wire               psel_i,
    input wire               penable_i,
    input wire [`ADDR_W-1:0] paddr_i,
    input wire [31:0]        prdata_o,
    input wire               pready_o,
    input wire               pslverr_o,
    input wire               switch_req_i,
    input wire               timeout_hold_i,
    input wire               top_beams_interrupted_i,
    input wire               safety_switch_outputs_o,
    input wire               gating_on_indication_o,
    input wire               restart_interlock_o,
    input wire               multiscan_filter_o,
    input wire               qualified_stop_en_o,
    input wire [1:0]         blank_tol_o,
    input wire [6:0]         seg_o
);
    localparam int END_MIN = 99 * TICK_CYCLES;
    localparam int END_MAX = 102 * TICK_CYCLES + 4;
    reg        req_q;
    reg        arm_q;
    reg [31:0] cnt_q;
    reg [2:0]  up_q;
    wire       settled = up_q == 3'h7;
    wire       m5      = seg_o == `SEG_FIVE;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    // ==========================================================
    // Request-removal timer, mode 5 only: qualified stop ends at once
    always @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            req_q <= 1'b0;
            arm_q <= 1'b0;
            cnt_q <= 32'h0;
            up_q  <= 3'h0;
        end
        else
        begin
            req_q <= switch_req_i;
            up_q  <= settled ? up_q : up_q + 3'h1;
            if (switch_req_i || !m5)
                arm_q <= 1'b0;
            else if (req_q && gating_on_indication_o)
                arm_q <= 1'b1;
            else if (!gating_on_indication_o)
                arm_q <= 1'b0;
            cnt_q <= arm_q ? cnt_q + 32'h1 : 32'h0;
        end
    end

    // ==========================================================
    // Assertions
    pready_a: assert property (psel_i && !penable_i |=> pready_o) else $error("no answer after setup");
    ready_once_a: assert property (pready_o |=> !pready_o) else $error("pready longer than one cycle");
    rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside access");
    unmapped_a: assert property (psel_i && !penable_i && paddr_i[7:4] != 4'h0 |=> pslverr_o)
        else $error("no error on unmapped address");
    seg_steady_a: assert property (settled |-> $stable(seg_o)) else $error("display changed");
    mode_func_a: assert property (settled |-> qualified_stop_en_o == (seg_o == `SEG_ONE || seg_o == `SEG_SIX)
        && restart_interlock_o == (seg_o != `SEG_DASH) && multiscan_filter_o == (seg_o != `SEG_DASH))
        else $error("mode functions wrong");
    blank_tol_a: assert property (settled |-> blank_tol_o == `BLANK_TOL_BEAMS) else $error("tolerance wrong");
    top_trip_a: assert property (seg_o == `SEG_SIX && top_beams_interrupted_i |=> !safety_switch_outputs_o)
        else $error("top beams not tripping");
    start5_a: assert property (m5 && $rose(switch_req_i) && !gating_on_indication_o && safety_switch_outputs_o
        |-> ##[1:3] gating_on_indication_o) else $error("mode 5 start missed");
    antival_a: assert property (!m5 && $rose(gating_on_indication_o) |-> switch_req_i && !timeout_hold_i)
        else $error("start without antivalent change");
    end_max_a: assert property (arm_q |-> cnt_q <= END_MAX) else $error("gating end too late");
    end_min_a: assert property ($fell(gating_on_indication_o) && arm_q |-> cnt_q >= END_MIN)
        else $error("gating end too early");

    end5_c: cover property (m5 && $fell(gating_on_indication_o) && arm_q);
    top_c: cover property (seg_o == `SEG_SIX && top_beams_interrupted_i && gating_on_indication_o);
    start16_c: cover property (!m5 && $rose(gating_on_indication_o));
endmodule

bind conveyor_gating_sequencer conveyor_gating_sequencer_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// >>> control_model.sv
// Machine control model driving the switching request and the timer hold.
// Assumes the bench commands it by go_i; the hold edge follows skew_i + 1 cycles after the request edge.
`timescale 1ns/1ps
module control_model (
    input  wire        mclk_i,
    input  wire        go_i,
    input  wire        use_hold_i,
    input  wire [15:0] skew_i,
    output reg         switch_req_o,
    output reg         timeout_hold_o
);
    reg [15:0] cnt_q;

    initial
    begin
        switch_req_o   = 1'b0;
        timeout_hold_o = 1'b1;
        cnt_q          = 16'h0;
    end

    // Hold is its own register, moved late, so it never mirrors the request edge
    always @(posedge mclk_i)
    begin
        if (go_i != switch_req_o)
        begin
            switch_req_o <= go_i;
            cnt_q        <= skew_i;
        end
        else if (cnt_q != 16'h0)
            cnt_q <= cnt_q - 16'h1;
        else if (use_hold_i)
            timeout_hold_o <= ~switch_req_o;
    end
endmodule

// >>> conveyor_gating_sequencer_tb.sv
// Self-checking bench of the conveyor gating sequencer.
// Assumes the design, its checker and the control model compiled alongside.
`timescale 1ns/1ps
`include "conveyor_gating_defs.vh"
module conveyor_gating_sequencer_tb;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [1:0]  strap = 2'h0;
    logic        go = 1'b0;
    logic        use_hold = 1'b0;
    logic        field = 1'b0;
    logic        top = 1'b0;
    logic [31:0] rd;
    logic        er;
    wire  [31:0] prdata;
    wire  [6:0]  seg;
    wire  [1:0]  tol;
    wire         pready, pslverr, req, hold, sso, gate_on, rlk, msf, qs, blk, irq;
    int          errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    logic [6:0]  segs [4] = '{`SEG_DASH, `SEG_ONE, `SEG_FIVE, `SEG_SIX};

    always #4 mclk = ~mclk;

    conveyor_gating_sequencer #(.TICK_CYCLES(4)) DUT (
        .mclk_i(mclk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .mode_strap_i(strap), .switch_req_i(req), .timeout_hold_i(hold), .field_interrupted_i(field),
        .top_beams_interrupted_i(top), .safety_switch_outputs_o(sso), .gating_on_indication_o(gate_on),
        .restart_interlock_o(rlk), .multiscan_filter_o(msf), .qualified_stop_en_o(qs),
        .blanking_en_o(blk), .blank_tol_o(tol), .seg_o(seg), .irq_o(irq)
    );

    control_model u_ctrl (
        .mclk_i         (mclk),
        .go_i           (go),
        .use_hold_i     (use_hold),
        .skew_i         (16'h0064),
        .switch_req_o   (req),
        .timeout_hold_o (hold)
    );

    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for the answer
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        chk("pready", 1'b1, pready);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    // Bounded wait for the gating indication to reach a level
    task automatic wt(input logic v, input int lim);
        int k;
        k = 0;
        while (gate_on !== v && k < lim)
        begin
            @(posedge mclk);
            k++;
        end
        chk("gating", v, gate_on);
    endtask

    // Strap is only taken at reset; the hold line is left to settle afterwards
    task automatic rst(input logic [1:0] m);
        arst_n <= 1'b0;
        strap <= m;
        go <= 1'b0;
        field <= 1'b0;
        top <= 1'b0;
        cyc(5);
        arst_n <= 1'b1;
        cyc(150);
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            errors++;
            stop_test;
        end
    end

    // ==========================================================
    // Scenarios
    initial
    begin
        @(posedge mclk);
        for (int i = 0; i < 4; i++)
        begin
            rst(i[1:0]);
            chk("seg", segs[i], seg);
            chk("qstop", i == 1 || i == 3, qs);
            chk("interlock", i != 0, rlk);
            chk("multiscan", i != 0, msf);
            chk("tolerance", `BLANK_TOL_BEAMS, tol);
            strap <= ~i[1:0];
            cyc(3);
            chk("seg_kept", segs[i], seg);
        end
        rst(2'h2);
        rdchk(`REG_IRQ_MASK, `IRQ_MASK_RST, "mask_rst");
        apb(1'b1, `REG_CTRL, 32'h1);
        rdchk(`REG_CTRL, 32'h1, "ctrl");
        chk("blank_en", 1'b1, blk);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 1'b1, er);
        apb(1'b1, `REG_IRQ_MASK, 32'h1 << `IRQ_START_BIT);
        go <= 1'b1;
        wt(1'b1, 10);
        cyc(2);
        chk("irq", 1'b1, irq);
        rdchk(`REG_IRQ_STAT, 32'h1 << `IRQ_START_BIT, "irq_stat");
        apb(1'b1, `REG_IRQ_STAT, 32'h1 << `IRQ_START_BIT);
        cyc(2);
        chk("irq_clr", 1'b0, irq);
        field <= 1'b1;
        cyc(20);
        field <= 1'b0;
        cyc(3600);
        chk("bridged", 1'b1, gate_on);
        field <= 1'b1;
        cyc(20);
        field <= 1'b0;
        cyc(40);
        go <= 1'b0;
        cyc(390);
        chk("end_min", 1'b1, gate_on);
        wt(1'b0, 60);
        go <= 1'b1;
        wt(1'b1, 10);
        field <= 1'b1;
        cyc(20);
        field <= 1'b0;
        cyc(3900);
        chk("filter", 1'b1, gate_on);
        wt(1'b0, 200);
        rst(2'h1);
        go <= 1'b1;
        cyc(100);
        chk("no_start", 1'b0, gate_on);
        go <= 1'b0;
        cyc(2100);
        use_hold <= 1'b1;
        go <= 1'b1;
        wt(1'b1, 120);
        go <= 1'b0;
        wt(1'b0, 120);
        chk("no_trip", 1'b1, sso);
        go <= 1'b1;
        wt(1'b1, 120);
        cyc(15900);
        chk("armed", 1'b1, sso);
        cyc(200);
        chk("trip", 1'b0, sso);
        chk("irq_masked", 1'b0, irq);
        rdchk(`REG_STATUS, 32'h180, "status");
        apb(1'b1, `REG_CTRL, 32'h1 << `CTRL_RESTART_BIT);
        cyc(2);
        chk("restart", 1'b1, sso);
        // Let the control settle to its idle levels before the reset is released
        go <= 1'b0;
        cyc(110);
        rst(2'h3);
        go <= 1'b1;
        wt(1'b1, 120);
        field <= 1'b1;
        top <= 1'b1;
        cyc(2);
        chk("top_trip", 1'b0, sso);
        stop_test;
    end
endmodule
